// *** sfsf_chk_assertions.sv ***
// Port checker for the frame status FIFO core.
// Sees only core ports; one clock domain, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sfsf_chk (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  input wire logic i_carrier_detect_n,
  input wire logic o_txd,
  input wire logic o_rx_serial,
  input wire logic o_tx_enable,
  input wire logic o_rx_enable,
  input wire logic o_cts_edge,
  input wire logic o_dcd_edge,
  input wire logic i_frame_end,
  input wire logic o_crc_reset
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  AST_RDY: assert property (i_psel && !i_penable |=> !o_pready ##1 o_pready)
    else $error("pready not in second access cycle");
  AST_PSE: assert property (o_pslverr |-> o_pready)
    else $error("pslverr outside completion");
  AST_CRC: assert property (o_crc_reset == $past(i_frame_end))
    else $error("crc reset not one cycle after frame end");
  AST_TXEN: assert property (!o_tx_enable |-> i_cts_n)
    else $error("transmit disabled while cts active");
  AST_RXEN: assert property (!o_rx_enable |-> i_carrier_detect_n)
    else $error("receive disabled while carrier active");
  AST_LOOP: assert property (o_rx_serial != i_rxd |-> o_txd == i_rxd)
    else $error("pin not echoed in loopback");
  // Pulse may trail by one extra stage of input capture
  AST_CTSE: assert property ($changed(i_cts_n) |-> ##[1:2] o_cts_edge)
    else $error("no cts transition pulse");
  AST_DCDE: assert property ($changed(i_carrier_detect_n) |-> ##[1:2] o_dcd_edge)
    else $error("no carrier transition pulse");
endmodule // sfsf_chk
bind sfsf_core sfsf_chk u_chk (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_rxd(i_rxd), .i_cts_n(i_cts_n), .i_carrier_detect_n(i_carrier_detect_n),
  .o_txd(o_txd), .o_rx_serial(o_rx_serial), .o_tx_enable(o_tx_enable),
  .o_rx_enable(o_rx_enable), .o_cts_edge(o_cts_edge), .o_dcd_edge(o_dcd_edge),
  .i_frame_end(i_frame_end), .o_crc_reset(o_crc_reset));
`default_nettype wire

// *** sfsf_core.v ***
// Frame status FIFO, echo/loopback routing and register access for one
// channel. Assumes synchronous frame events from the receiver and an
// APB master on the same clock.
//
// Behaviour
// - Echo mode: receive pin drives transmit pin directly
// - Echo ignores CTS enable, transitions still flagged
// - Loopback: transmit feeds receiver, pin still echoed
// - Loopback ignores CTS/carrier enables, transitions flagged
// - Ten entries: 14-bit count plus five status
// - FIFO runs only if enabled and SDLC
// - Disable or reset clears pointers and enable
// - Disabled: indices four-seven alias zero-three
// - Extended readback bit two shows enable
// - Frame end loads count/status, advances write
// - Abort also loads count, counter restarts
// - Frame-ending flag resets CRC checker
// - Head read when not empty; guarded pop
// - Empty: live status, no underflow, counts undefined
// - High count bit six: data available, latched
// - Residue, overrun, CRC stored; others live
// - End-of-frame reads one from FIFO
// - Load when full sets overflow; toggle clears
// - Pointer write then indirect access, pointer clears
// - Direct address from AD4-AD1, channel by shift
// - Status register holds residue, overrun, CRC, EOF
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sfsf_defines.vh"

module sfsf_core #(
  parameter DEPTH = `SFSF_DEPTH,
  parameter AW = 4,
  parameter CHANNEL = 0
) (
  input wire i_core_clk,
  input wire i_arst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire i_rxd,
  input wire i_tx_serial,
  input wire i_cts_n,
  input wire i_carrier_detect_n,
  output wire o_txd,
  output wire o_rx_serial,
  output wire o_tx_enable,
  output wire o_rx_enable,
  output wire o_cts_edge,
  output wire o_dcd_edge,
  input wire i_sdlc_mode,
  input wire i_channel_reset,
  input wire i_rx_byte,
  input wire i_frame_end,
  input wire i_frame_abort,
  input wire [2:0] i_residue,
  input wire i_overrun,
  input wire i_crc_error,
  input wire i_all_sent,
  input wire i_parity_error,
  input wire i_eof_live,
  output wire o_crc_reset,
  input wire [7:0] i_main_status,
  input wire [7:0] i_vector,
  input wire [7:0] i_pending,
  input wire [7:0] i_ext_int_ctl,
  input wire [7:0] i_rx_data,
  output wire o_rx_data_read,
  output wire [7:0] o_tx_data,
  output wire o_tx_data_load
);

  localparam [AW-1:0] PTR_LAST = DEPTH - 1;
  localparam [AW-1:0] CNT_FULL = DEPTH;
  localparam [AW-1:0] CNT_ONE = 1;
  localparam [`SFSF_CNT_W-1:0] BYTE_ONE = 1;

  // Control and APB state
  reg [7:0] fctl_reg;
  reg [7:0] mode_reg;
  reg [3:0] ptr_reg;
  reg wait_reg;
  reg [31:0] prdata_reg;
  reg slverr_reg;
  reg [7:0] tx_data_reg;
  reg tx_load_reg;
  reg rx_read_reg;
  // FIFO state
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW-1:0] cnt_reg;
  reg [AW-1:0] cnt_next;
  reg ovf_reg;
  reg armed_reg;
  reg [`SFSF_CNT_W-1:0] bytes_reg;
  reg crc_rst_reg;
  reg cts_prev_reg;
  reg dcd_prev_reg;
  reg cts_edge_reg;
  reg dcd_edge_reg;

  wire [`SFSF_WIDTH-1:0] head;
  wire [`SFSF_WIDTH-1:0] entry;
  wire echo_on;
  wire loop_on;
  wire active;
  wire not_empty;
  wire full;
  wire frame_evt;
  wire load;
  wire wr_en;
  wire pop;
  wire access;
  wire done;
  wire is_cmd;
  wire is_data;
  wire is_ind;
  wire is_dir;
  wire [7:0] ad;
  wire chan_sel;
  wire chan_ok;
  wire [3:0] idx;
  wire [3:0] eff;
  wire hit;
  wire rd_done;
  wire wr_done;
  wire fifo_src;
  reg [7:0] rdata;
  reg [7:0] spec;

  // Serial routing; kept combinational so the echoed stream gets no delay
  assign echo_on = mode_reg[`SFSF_MODE_ECHO_BIT];
  assign loop_on = mode_reg[`SFSF_MODE_LOOP_BIT];
  assign o_txd = (echo_on || loop_on) ? i_rxd : i_tx_serial;
  assign o_rx_serial = loop_on ? i_tx_serial : i_rxd;
  assign o_tx_enable = (echo_on || loop_on) ? 1'b1 : ~i_cts_n;
  assign o_rx_enable = loop_on ? 1'b1 : ~i_carrier_detect_n;
  assign o_cts_edge = cts_edge_reg;
  assign o_dcd_edge = dcd_edge_reg;

  // Transitions are flagged whatever the mode
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cts_prev_reg <= 1'b1;
      dcd_prev_reg <= 1'b1;
      cts_edge_reg <= 1'b0;
      dcd_edge_reg <= 1'b0;
    end
    else
    begin
      cts_prev_reg <= i_cts_n;
      dcd_prev_reg <= i_carrier_detect_n;
      cts_edge_reg <= cts_prev_reg ^ i_cts_n;
      dcd_edge_reg <= dcd_prev_reg ^ i_carrier_detect_n;
    end
  end

  // APB decode: one wait state so read data comes from a flip-flop
  assign access = i_psel && i_penable;
  assign o_pready = access && wait_reg;
  assign done = o_pready;
  assign o_prdata = prdata_reg;
  assign o_pslverr = o_pready && slverr_reg;
  assign is_cmd = (i_paddr == `SFSF_OFF_CMD);
  assign is_data = (i_paddr == `SFSF_OFF_DATA);
  assign is_ind = (i_paddr == `SFSF_OFF_IND);
  assign is_dir = (i_paddr[11:10] == `SFSF_DIR_SEL) && (i_paddr[1:0] == 2'h0);
  assign ad = i_paddr[9:2];
  assign chan_sel = mode_reg[`SFSF_MODE_SHL_BIT] ? ad[5] : ad[0];
  assign chan_ok = (chan_sel == CHANNEL[0]);
  assign idx = is_ind ? ptr_reg : (is_data ? `SFSF_IDX_DATA : ad[4:1]);
  assign hit = is_cmd || is_data || is_ind || (is_dir && chan_ok);
  // Backward-compatible images while the FIFO is off
  assign eff = (!active && (idx[3:2] == 2'h1)) ? {2'h0, idx[1:0]} : idx;
  assign rd_done = done && !i_pwrite && hit && !is_cmd;
  assign wr_done = done && i_pwrite && hit;

  // FIFO control
  assign active = fctl_reg[`SFSF_FIFO_EN_BIT] && i_sdlc_mode;
  assign not_empty = (cnt_reg != {AW{1'b0}});
  assign full = (cnt_reg == CNT_FULL);
  assign frame_evt = i_frame_end || i_frame_abort;
  assign load = active && frame_evt;
  assign wr_en = load && !full;
  assign fifo_src = active && not_empty;
  // One pop per high-count read, never from an empty FIFO
  assign pop = rd_done && (eff == `SFSF_IDX_SPEC) && armed_reg && fifo_src;
  assign entry = {i_crc_error, i_overrun, i_residue, bytes_reg};
  assign o_crc_reset = crc_rst_reg;
  assign o_tx_data = tx_data_reg;
  assign o_tx_data_load = tx_load_reg;
  assign o_rx_data_read = rx_read_reg;

  sfsf_mem #(
    .WIDTH(`SFSF_WIDTH),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .i_core_clk(i_core_clk),
    .i_wr_en(wr_en),
    .i_wr_addr(wr_ptr_reg),
    .i_wr_data(entry),
    .i_rd_addr(rd_ptr_reg),
    .o_rd_data(head)
  );

  // Special receive status: stored fields from the head, the rest live
  always @*
  begin
    if (fifo_src)
    begin
      spec = {1'b1, head[18], head[17], i_parity_error, head[16:14], i_all_sent};
    end
    else
    begin
      spec = {i_eof_live, i_crc_error, i_overrun, i_parity_error, i_residue, i_all_sent};
    end
  end

  // Read data; count bits are don't-care when empty
  always @*
  begin
    case (eff)
      `SFSF_IDX_MAIN: rdata = i_main_status;
      `SFSF_IDX_SPEC: rdata = spec;
      `SFSF_IDX_VEC: rdata = i_vector;
      `SFSF_IDX_PEND: rdata = i_pending;
      `SFSF_IDX_CNT_LO: rdata = head[7:0];
      `SFSF_IDX_CNT_HI: rdata = {ovf_reg, not_empty, head[13:8]};
      `SFSF_IDX_DATA: rdata = i_rx_data;
      `SFSF_IDX_EXTRB: rdata = {i_ext_int_ctl[7:3], fctl_reg[`SFSF_FIFO_EN_BIT],
                                i_ext_int_ctl[1:0]};
      default: rdata = 8'h00;
    endcase
  end

  // APB response registers
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wait_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end
    else
    begin
      wait_reg <= access && !wait_reg;
      if (access && !wait_reg)
      begin
        slverr_reg <= !hit;
        if (!i_pwrite && hit)
        begin
          prdata_reg <= {24'h00_0000, (is_cmd ? i_main_status : rdata)};
        end
        else
        begin
          prdata_reg <= 32'h0000_0000;
        end
      end
    end
  end

  // Register writes, pointer handling and data strobes
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      fctl_reg <= `SFSF_FCTL_RST;
      mode_reg <= `SFSF_MODE_RST;
      ptr_reg <= 4'h0;
      tx_data_reg <= 8'h00;
      tx_load_reg <= 1'b0;
      rx_read_reg <= 1'b0;
    end
    else
    begin
      tx_load_reg <= 1'b0;
      rx_read_reg <= rd_done && (eff == `SFSF_IDX_DATA);
      if (is_ind && done)
      begin
        ptr_reg <= 4'h0;
      end
      else if (wr_done && (is_cmd || (is_dir && (eff == `SFSF_IDX_MAIN))))
      begin
        ptr_reg <= i_pwdata[3:0];
      end
      if (wr_done && !is_cmd)
      begin
        case (eff)
          `SFSF_IDX_FCTL: fctl_reg <= i_pwdata[7:0];
          `SFSF_IDX_MODE: mode_reg <= i_pwdata[7:0];
          `SFSF_IDX_DATA:
          begin
            tx_data_reg <= i_pwdata[7:0];
            tx_load_reg <= 1'b1;
          end
          default: tx_load_reg <= 1'b0;
        endcase
      end
      if (i_channel_reset)
      begin
        fctl_reg <= `SFSF_FCTL_RST;
      end
    end
  end

  // Occupancy
  always @*
  begin
    cnt_next = cnt_reg;
    if (wr_en && !pop)
    begin
      cnt_next = cnt_reg + CNT_ONE;
    end
    else if (pop && !wr_en)
    begin
      cnt_next = cnt_reg - CNT_ONE;
    end
  end

  // FIFO pointers, overflow, avail latch and byte counter
  always @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      cnt_reg <= {AW{1'b0}};
      ovf_reg <= 1'b0;
      armed_reg <= 1'b0;
      bytes_reg <= {`SFSF_CNT_W{1'b0}};
      crc_rst_reg <= 1'b0;
    end
    else
    begin
      crc_rst_reg <= i_frame_end;
      if (frame_evt)
      begin
        bytes_reg <= {`SFSF_CNT_W{1'b0}};
      end
      else if (i_rx_byte)
      begin
        bytes_reg <= bytes_reg + BYTE_ONE;
      end
      if (!active || i_channel_reset)
      begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        cnt_reg <= {AW{1'b0}};
        armed_reg <= 1'b0;
      end
      else
      begin
        if (wr_en)
        begin
          wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? {AW{1'b0}} : wr_ptr_reg + CNT_ONE;
        end
        if (pop)
        begin
          rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? {AW{1'b0}} : rd_ptr_reg + CNT_ONE;
        end
        cnt_reg <= cnt_next;
        // High-count read latches availability and arms one pop
        if (rd_done && (eff == `SFSF_IDX_CNT_HI))
        begin
          armed_reg <= not_empty;
        end
        else if (rd_done && (eff == `SFSF_IDX_SPEC))
        begin
          armed_reg <= 1'b0;
        end
      end
      // Set wins; only a fresh enable (or a reset) clears it
      if (load && full)
      begin
        ovf_reg <= 1'b1;
      end
      else if (i_channel_reset || (wr_done && !is_cmd && (eff == `SFSF_IDX_FCTL) &&
               i_pwdata[`SFSF_FIFO_EN_BIT] && !fctl_reg[`SFSF_FIFO_EN_BIT]))
      begin
        ovf_reg <= 1'b0;
      end
    end
  end

endmodule // sfsf_core

`default_nettype wire

// *** sfsf_defines.vh ***
// Constants for the frame status FIFO block: APB offsets, register
// indices, field positions and sizes.
// Assumes a 12-bit byte address and 32-bit APB data.
`ifndef SFSF_DEFINES_VH
`define SFSF_DEFINES_VH

// APB byte addresses
`define SFSF_OFF_CMD 12'h000
`define SFSF_OFF_DATA 12'h004
`define SFSF_OFF_IND 12'h008
`define SFSF_DIR_SEL 2'h1

// Register indices
`define SFSF_IDX_MAIN 4'h0
`define SFSF_IDX_SPEC 4'h1
`define SFSF_IDX_VEC 4'h2
`define SFSF_IDX_PEND 4'h3
`define SFSF_IDX_CNT_LO 4'h6
`define SFSF_IDX_CNT_HI 4'h7
`define SFSF_IDX_DATA 4'h8
`define SFSF_IDX_MODE 4'hE
`define SFSF_IDX_FCTL 4'hF
`define SFSF_IDX_EXTRB 4'hF

// Field positions
`define SFSF_FIFO_EN_BIT 2
`define SFSF_MODE_ECHO_BIT 0
`define SFSF_MODE_LOOP_BIT 1
`define SFSF_MODE_SHL_BIT 2
`define SFSF_HI_AVAIL_BIT 6
`define SFSF_HI_OVF_BIT 7

// Reset values
`define SFSF_FCTL_RST 8'h00
`define SFSF_MODE_RST 8'h00

// FIFO geometry
`define SFSF_DEPTH 10
`define SFSF_WIDTH 19
`define SFSF_CNT_W 14

`endif

// *** sfsf_mem.v ***
// Small storage array for the frame status FIFO.
// One write port, one read port; read data registered, write-first.
`timescale 1ns/1ps
`default_nettype none

module sfsf_mem #(
  parameter WIDTH = 19,
  parameter DEPTH = 10,
  parameter AW = 4
) (
  input wire i_core_clk,
  input wire i_wr_en,
  input wire [AW-1:0] i_wr_addr,
  input wire [WIDTH-1:0] i_wr_data,
  input wire [AW-1:0] i_rd_addr,
  output reg [WIDTH-1:0] o_rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge i_core_clk)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
    // Bypass so a freshly loaded head is seen at once
    if (i_wr_en && (i_wr_addr == i_rd_addr))
    begin
      o_rd_data <= i_wr_data;
    end
    else
    begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule // sfsf_mem

`default_nettype wire

// *** sfsf_rx_model.sv ***
// Receiver-side frame source: byte pulses, then one closing event.
// Called from the bench; outputs change just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module sfsf_rx_model (
  input wire logic i_core_clk,
  output logic o_rx_byte,
  output logic o_frame_end,
  output logic o_frame_abort,
  output logic [2:0] o_residue,
  output logic o_overrun,
  output logic o_crc_error
);
  initial
  begin
    {o_rx_byte, o_frame_end, o_frame_abort, o_residue, o_overrun, o_crc_error} = 8'h00;
  end
  // Status valid only in the closing cycle, so live reads see zero
  task send(input int n, input logic ab);
    begin
      repeat (n)
      begin
        @(posedge i_core_clk);
        o_rx_byte <= 1'b1;
      end
      @(posedge i_core_clk);
      o_rx_byte <= 1'b0;
      o_frame_end <= !ab;
      o_frame_abort <= ab;
      {o_crc_error, o_overrun, o_residue} <= {n[1], n[0], n[2:0]};
      @(posedge i_core_clk);
      {o_frame_end, o_frame_abort, o_crc_error, o_overrun, o_residue} <= 7'h00;
    end
  endtask
endmodule // sfsf_rx_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for sfsf_core over APB with a frame source model.
// Assumes one fixed APB wait state; master waits on pready anyway.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sdlc = 1'b0, chrst = 1'b0;
  logic rxd = 1'b1, txs = 1'b0, cts_n = 1'b1, dcd_n = 1'b1, par = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, r;
  logic [7:0] live = 8'h5A;
  logic e;
  wire [31:0] prdata;
  wire [7:0] txdat;
  wire [2:0] res;
  wire pready, pslverr, rxb, fend, fab, ovr, crc, txd, rxs, txen, rxen;
  wire txld, rxrd, ctse, dcde;
  integer n_errors = 0, check_count = 0, i, k;
  always #25 clk = ~clk;
  sfsf_rx_model u_rx (.i_core_clk(clk), .o_rx_byte(rxb), .o_frame_end(fend),
    .o_frame_abort(fab), .o_residue(res), .o_overrun(ovr), .o_crc_error(crc));
  sfsf_core u_dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .i_tx_serial(txs),
    .i_cts_n(cts_n), .i_carrier_detect_n(dcd_n), .o_txd(txd), .o_rx_serial(rxs),
    .o_tx_enable(txen), .o_rx_enable(rxen), .o_cts_edge(ctse), .o_dcd_edge(dcde),
    .i_sdlc_mode(sdlc), .i_channel_reset(chrst), .i_rx_byte(rxb), .i_frame_end(fend),
    .i_frame_abort(fab), .i_residue(res), .i_overrun(ovr), .i_crc_error(crc),
    .i_all_sent(1'b1), .i_parity_error(par), .i_eof_live(1'b0), .o_crc_reset(),
    .i_main_status(live), .i_vector(~live), .i_pending({live[3:0], live[7:4]}),
    .i_ext_int_ctl(8'hA0), .i_rx_data(live + 8'h01), .o_rx_data_read(rxrd),
    .o_tx_data(txdat), .o_tx_data_load(txld));
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [7:0] exp);
    begin
      check_count++;
      if (got !== {24'h0, exp})
      begin
        n_errors++;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer t;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      t = 0;
      @(posedge clk);
      // Hold the request until pready is seen at a rising edge
      while (pready !== 1'b1 && t < 20)
      begin
        @(posedge clk);
        t++;
      end
      r = prdata;
      e = pslverr;
      if (pready !== 1'b1)
      begin
        n_errors++;
        report_and_stop;
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task ird(input logic [3:0] idx);
    begin
      xfer(1'b1, 12'h000, {28'h0, idx});
      xfer(1'b0, 12'h008, 32'h0000_0000);
    end
  endtask
  task wt(input logic [3:0] idx, input logic [7:0] d);
    begin
      xfer(1'b1, 12'h000, {28'h0, idx});
      xfer(1'b1, 12'h008, {24'h0, d});
    end
  endtask
  function automatic logic [7:0] ex(input int j);
    ex = (j == 0) ? live : (j == 1) ? 8'h01 : (j == 2) ? ~live : {live[3:0], live[7:4]};
  endfunction
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      ird(i);
      chk("alias", r, ex(i % 4));
    end
    ird(15);
    chk("readback off", r, 8'hA0);
    xfer(1'b0, 12'h710, 32'h0000_0000);
    chk("direct", r, ~live);
    xfer(1'b0, 12'h414, 32'h0000_0000);
    chk("wrong channel", e, 8'h01);
    xfer(1'b0, 12'h0C0, 32'h0000_0000);
    chk("unmapped", e, 8'h01);
    xfer(1'b1, 12'h004, 32'h0000_003C);
    @(negedge clk);
    chk("tx data", txdat, 8'h3C);
    chk("tx load", txld, 8'h01);
    xfer(1'b0, 12'h004, 32'h0000_0000);
    chk("rx data", r, live + 8'h01);
    @(negedge clk);
    chk("rx read", rxrd, 8'h01);
    @(posedge clk);
    $display("test registers done");
    sdlc <= 1'b1;
    wt(15, 8'h04);
    ird(15);
    chk("readback on", r, 8'hA4);
    for (k = 1; k <= 11; k++)
      u_rx.send(k, k == 3);
    // Parity is live: it must show through stored status too
    par <= 1'b1;
    // Host order: high count, low count, then status
    for (k = 1; k <= 10; k++)
    begin
      ird(7);
      chk("high count", r, 8'hC0);
      ird(6);
      chk("low count", r, k);
      ird(1);
      chk("fifo status", r, {1'b1, k[1], k[0], 1'b1, k[2:0], 1'b1});
      if (k == 1)
        ird(1);
    end
    ird(7);
    chk("high empty", r & 32'h0000_00C0, 8'h80);
    ird(1);
    chk("live status", r, 8'h11);
    wt(15, 8'h00);
    wt(15, 8'h04);
    ird(7);
    chk("ovf cleared", r & 32'h0000_00C0, 8'h00);
    @(posedge clk);
    chrst <= 1'b1;
    @(posedge clk);
    chrst <= 1'b0;
    ird(15);
    chk("reset enable", r, 8'hA0);
    u_rx.send(2, 1'b0);
    wt(15, 8'h04);
    ird(7);
    chk("dropped load", r & 32'h0000_00C0, 8'h00);
    $display("test fifo done");
    wt(14, 8'h01); // no transmit data written while echoing
    @(negedge clk);
    chk("echo txd", txd, 8'h01);
    chk("echo txen", txen, 8'h01);
    @(posedge clk);
    cts_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("cts edge", ctse, 8'h01);
    @(posedge clk);
    cts_n <= 1'b1;
    wt(14, 8'h02);
    {txs, rxd, dcd_n} <= 3'h5;
    @(negedge clk);
    chk("loop rx", rxs, 8'h01);
    chk("loop txd", txd, 8'h00);
    chk("loop rxen", rxen, 8'h01);
    @(posedge clk);
    dcd_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("dcd edge", dcde, 8'h01);
    wt(14, 8'h04);
    xfer(1'b0, 12'h414, 32'h0000_0000);
    chk("shift left", r, ~live);
    wt(14, 8'h00);
    @(negedge clk);
    chk("normal txd", txd, 8'h01);
    $display("test routing done");
    report_and_stop;
  end
endmodule // tb
`default_nettype wire
